// >>> twe_defs.vh
// Constants for the two-wire memory target front end
`ifndef TWE_DEFS_VH
`define TWE_DEFS_VH
`define TWE_PREFIX 5'h14
`define TWE_PREFIX_MSB 7
`define TWE_PREFIX_LSB 3
`define TWE_SEL_HIGH_BIT 2
`define TWE_SEL_LOW_BIT 1
`define TWE_RW_BIT 0
`define TWE_WORD_BITS 8
`define TWE_CLK_MHZ 100
`define TWE_TWR_MS 5
`define TWE_TWR_CYCLES (`TWE_TWR_MS * 1000 * `TWE_CLK_MHZ)
`define TWE_FIFO_WIDTH 8
`define TWE_FIFO_DEPTH 16
`define TWE_FIFO_AW 4
`endif

// >>> twe_sync.v
// Two flip-flop synchroniser for one pin level
`timescale 1ns/100ps
`default_nettype none
module twe_sync (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_d,
   output reg o_q
);
   reg meta;
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta <= 1'b1;
         o_q <= 1'b1;
      end else begin
         meta <= i_d;
         o_q <= meta;
      end
   end
endmodule // twe_sync
`default_nettype wire

// >>> twe_fifo.v
// Received-word FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module twe_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_flush,
   input wire i_in_valid,
   output wire o_in_ready,
   input wire [WIDTH-1:0] i_in_data,
   output wire o_out_valid,
   input wire i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr;
   reg [AW:0] rd_ptr;
   wire empty = (wr_ptr == rd_ptr);
   wire full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) &&
      (wr_ptr[AW] != rd_ptr[AW]);
   wire push = i_in_valid && !full;
   wire pop = i_out_ready && !empty;
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = mem[rd_ptr[AW-1:0]];
   always @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= i_in_data;
      end
   end
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else if (i_flush) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule // twe_fifo
`default_nettype wire

// >>> twe_target.v
// Two-wire memory target front end: framing, address match, ack, write window
//
// Behaviour
// - Data changes with clock high mark conditions
// - Data falling, clock high is start
// - Data rising, clock high is stop
// - Eight-bit words, ack low on ninth clock
// - Standby at power-up, after stop without write, and after write window
// - Device address word follows every start
// - Top five address bits must match prefix
// - Two address bits match select pins
// - Unconnected select pin reads as low
// - Address bit zero: high read, low write
// - Match acks; mismatch no ack, standby
// - Write protect high blocks all writes
// - Self-timed write from stop, bounded window
// - Sample on clock rise, drive after fall
// - Ignore everything during internal write
`timescale 1ns/100ps
`default_nettype none
`include "twe_defs.vh"
module twe_target #(
   parameter TWR_CYCLES = `TWE_TWR_CYCLES
) (
   input wire I_CLK,
   input wire I_RESET_N,
   input wire I_SCL,
   input wire I_SDA,
   output wire O_SDA,
   output wire O_SDA_OE_N,
   input wire I_SELECT_PIN_HIGH,
   input wire I_SELECT_PIN_LOW,
   input wire I_WRITE_PROTECT,
   input wire I_READ_DATA,
   output reg O_READ_DATA_REQ,
   output wire O_WORD_VALID,
   input wire I_WORD_READY,
   output wire [7:0] O_WORD_DATA,
   output reg O_FRAME_START,
   output reg O_WRITE_COMMIT,
   output reg O_READ_MODE,
   output reg O_SELECTED,
   output reg O_STANDBY,
   output reg O_WRITE_BUSY
);
   localparam ST_IDLE = 6'b000001;
   localparam ST_ADDR = 6'b000010;
   localparam ST_ACK = 6'b000100;
   localparam ST_RXD = 6'b001000;
   localparam ST_TXD = 6'b010000;
   localparam ST_MACK = 6'b100000;

   reg rst_meta;
   reg rst_n;
   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   wire scl_s;
   wire sda_s;
   wire sel_hi_s;
   wire sel_lo_s;
   wire wp_s;
   twe_sync u_sync_scl (.i_clk(I_CLK), .i_rst_n(rst_n), .i_d(I_SCL),
      .o_q(scl_s));
   twe_sync u_sync_sda (.i_clk(I_CLK), .i_rst_n(rst_n), .i_d(I_SDA),
      .o_q(sda_s));
   // Floating select pins need no pull outside; x or z folds to low
   twe_sync u_sync_shi (.i_clk(I_CLK), .i_rst_n(rst_n),
      .i_d(I_SELECT_PIN_HIGH === 1'b1), .o_q(sel_hi_s));
   twe_sync u_sync_slo (.i_clk(I_CLK), .i_rst_n(rst_n),
      .i_d(I_SELECT_PIN_LOW === 1'b1), .o_q(sel_lo_s));
   twe_sync u_sync_wp (.i_clk(I_CLK), .i_rst_n(rst_n),
      .i_d(I_WRITE_PROTECT === 1'b1), .o_q(wp_s));

   reg scl_d;
   reg sda_d;
   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end
   wire scl_rise = scl_s && !scl_d;
   wire scl_fall = !scl_s && scl_d;
   // Only data moving under a steady high clock is a condition
   wire start_cond = scl_s && scl_d && sda_d && !sda_s;
   wire stop_cond = scl_s && scl_d && !sda_d && sda_s;

   reg [5:0] state;
   reg [3:0] bit_cnt;
   reg [7:0] shift;
   reg ack_ok;
   reg is_write;
   reg got_data;
   reg drive_low;
   reg [31:0] twr_cnt;

   wire fifo_in_ready;
   reg fifo_push;
   reg [7:0] fifo_data;
   wire [4:0] rx_prefix = shift[`TWE_PREFIX_MSB:`TWE_PREFIX_LSB];
   wire addr_match = (rx_prefix == `TWE_PREFIX) &&
      (shift[`TWE_SEL_HIGH_BIT] == sel_hi_s) &&
      (shift[`TWE_SEL_LOW_BIT] == sel_lo_s);

   twe_fifo #(
      .WIDTH(`TWE_FIFO_WIDTH),
      .DEPTH(`TWE_FIFO_DEPTH),
      .AW(`TWE_FIFO_AW)
   ) u_fifo (
      .i_clk(I_CLK),
      .i_rst_n(rst_n),
      .i_flush(1'b0),
      .i_in_valid(fifo_push),
      .o_in_ready(fifo_in_ready),
      .i_in_data(fifo_data),
      .o_out_valid(O_WORD_VALID),
      .i_out_ready(I_WORD_READY),
      .o_out_data(O_WORD_DATA)
   );

   // Open drain: enable low only while pulling the line low
   assign O_SDA = 1'b0;
   assign O_SDA_OE_N = !drive_low;

   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         ack_ok <= 1'b0;
         is_write <= 1'b0;
         got_data <= 1'b0;
         drive_low <= 1'b0;
         twr_cnt <= 32'h0000_0000;
         fifo_push <= 1'b0;
         fifo_data <= 8'h00;
         O_READ_DATA_REQ <= 1'b0;
         O_FRAME_START <= 1'b0;
         O_WRITE_COMMIT <= 1'b0;
         O_READ_MODE <= 1'b0;
         O_SELECTED <= 1'b0;
         O_STANDBY <= 1'b1;
         O_WRITE_BUSY <= 1'b0;
      end else begin
         fifo_push <= 1'b0;
         O_READ_DATA_REQ <= 1'b0;
         O_FRAME_START <= 1'b0;
         O_WRITE_COMMIT <= 1'b0;
         if (O_WRITE_BUSY) begin
            // Bus is deaf until the internal write ends
            drive_low <= 1'b0;
            state <= ST_IDLE;
            if (twr_cnt >= TWR_CYCLES - 1) begin
               O_WRITE_BUSY <= 1'b0;
               twr_cnt <= 32'h0000_0000;
               O_STANDBY <= 1'b1;
            end else begin
               twr_cnt <= twr_cnt + 32'h0000_0001;
            end
         end else if (start_cond) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            drive_low <= 1'b0;
            got_data <= 1'b0;
            O_SELECTED <= 1'b0;
            O_STANDBY <= 1'b0;
            O_FRAME_START <= 1'b1;
         end else if (stop_cond) begin
            state <= ST_IDLE;
            drive_low <= 1'b0;
            O_SELECTED <= 1'b0;
            if (O_SELECTED && is_write && got_data && !wp_s) begin
               O_WRITE_BUSY <= 1'b1;
               O_WRITE_COMMIT <= 1'b1;
            end else begin
               O_STANDBY <= 1'b1;
            end
         end else begin
            case (state)
               ST_IDLE: begin
                  drive_low <= 1'b0;
               end
               ST_ADDR, ST_RXD: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda_s};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == 4'h8) begin
                     bit_cnt <= 4'h0;
                     if (state == ST_ADDR) begin
                        if (addr_match) begin
                           drive_low <= 1'b1;
                           ack_ok <= 1'b1;
                           O_SELECTED <= 1'b1;
                           O_READ_MODE <= shift[`TWE_RW_BIT];
                           is_write <= !shift[`TWE_RW_BIT];
                           state <= ST_ACK;
                        end else begin
                           state <= ST_IDLE;
                           O_STANDBY <= 1'b1;
                        end
                     end else begin
                        // Full FIFO or protect: no ack
                        ack_ok <= fifo_in_ready && !wp_s;
                        drive_low <= fifo_in_ready && !wp_s;
                        fifo_push <= fifo_in_ready && !wp_s;
                        fifo_data <= shift;
                        got_data <= got_data ||
                           (fifo_in_ready && !wp_s);
                        state <= ST_ACK;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     drive_low <= 1'b0;
                     if (!ack_ok) begin
                        state <= ST_IDLE;
                     end else if (O_READ_MODE) begin
                        state <= ST_TXD;
                        drive_low <= !I_READ_DATA;
                        O_READ_DATA_REQ <= 1'b1;
                        bit_cnt <= 4'h1;
                     end else begin
                        state <= ST_RXD;
                     end
                  end
               end
               ST_TXD: begin
                  if (scl_fall) begin
                     if (bit_cnt == 4'h8) begin
                        drive_low <= 1'b0;
                        state <= ST_MACK;
                     end else begin
                        drive_low <= !I_READ_DATA;
                        O_READ_DATA_REQ <= 1'b1;
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                  end
               end
               ST_MACK: begin
                  if (scl_rise) begin
                     ack_ok <= !sda_s;
                  end else if (scl_fall) begin
                     if (ack_ok) begin
                        state <= ST_TXD;
                        drive_low <= !I_READ_DATA;
                        O_READ_DATA_REQ <= 1'b1;
                        bit_cnt <= 4'h1;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule // twe_target
`default_nettype wire

// >>> twe_target_monitor.sv
// Port-level concurrent checks for the two-wire target front end
`timescale 1ns/100ps
`default_nettype none
module twe_target_monitor #(
   parameter TWR_CYCLES = 20
) (
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   input wire logic I_SCL,
   input wire logic I_SDA,
   input wire logic O_SDA_OE_N,
   input wire logic I_WRITE_PROTECT,
   input wire logic O_READ_DATA_REQ,
   input wire logic O_WORD_VALID,
   input wire logic O_FRAME_START,
   input wire logic O_READ_MODE,
   input wire logic O_SELECTED,
   input wire logic O_STANDBY,
   input wire logic O_WRITE_COMMIT,
   input wire logic O_WRITE_BUSY
);
   logic [31:0] busy_cnt;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RESET_N);
   // Window is too long to unroll, so count it
   always_ff @(posedge I_CLK or negedge I_RESET_N)
      if (!I_RESET_N) busy_cnt <= 32'h0;
      else busy_cnt <= O_WRITE_BUSY ? busy_cnt + 32'h1 : 32'h0;
   sby_busy_a: assert property (O_WRITE_BUSY |-> !O_STANDBY)
      else $error("standby during write window");
   commit_busy_a: assert property (O_WRITE_COMMIT |-> ##[0:2] O_WRITE_BUSY)
      else $error("commit without write window");
   busy_max_a: assert property (busy_cnt <= TWR_CYCLES + 2)
      else $error("write window too long");
   busy_end_a: assert property ($fell(O_WRITE_BUSY) |->
      busy_cnt >= TWR_CYCLES - 2 ##[0:2] O_STANDBY)
      else $error("write window end wrong");
   busy_quiet_a: assert property (O_WRITE_BUSY |-> O_SDA_OE_N && !O_FRAME_START)
      else $error("bus answered during write window");
   oe_edge_a: assert property ($changed(O_SDA_OE_N) |-> !I_SCL)
      else $error("data drive changed with clock high");
   start_det_a: assert property (I_SCL && $fell(I_SDA) && !O_WRITE_BUSY
      |-> ##[2:5] O_FRAME_START)
      else $error("start not seen");
   stop_det_a: assert property (I_SCL && $rose(I_SDA) |-> ##[2:5] !O_SELECTED)
      else $error("stop did not deselect");
   wp_block_a: assert property ($rose(O_WORD_VALID) |-> !$past(I_WRITE_PROTECT, 4))
      else $error("word taken while protected");
   read_req_a: assert property (O_READ_DATA_REQ |-> O_READ_MODE && O_SELECTED)
      else $error("read request outside read");
endmodule // twe_target_monitor
bind twe_target twe_target_monitor #(.TWR_CYCLES(TWR_CYCLES)) mon_u (.*);
`default_nettype wire

// >>> twe_ctrl_model.sv
// Behavioural two-wire bus controller for the target front end
`timescale 1ns/100ps
`default_nettype none
module twe_ctrl_model (
   output logic o_scl,
   output logic o_sda,
   input wire logic i_sda
);
   localparam realtime Q = 31.25;
   // Clock stands high and data released between frames
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // Data moves a quarter period after the fall, sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      o_sda = b;
      #Q o_scl = 1'b1;
      #Q r = i_sda;
      #Q o_scl = 1'b0;
      #Q;
   endtask
   task automatic start;
      o_sda = 1'b1;
      #Q o_scl = 1'b1;
      #(2 * Q) o_sda = 1'b0;
      #(2 * Q) o_scl = 1'b0;
      #Q;
   endtask
   task automatic stop;
      o_sda = 1'b0;
      #Q o_scl = 1'b1;
      #(2 * Q) o_sda = 1'b1;
      #(4 * Q);
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, ack);
   endtask
   task automatic recv_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(ack, r);
   endtask
   // Nine released clocks free a target stuck mid-byte
   task automatic recover;
      logic r;
      repeat (9) bit_io(1'b1, r);
   endtask
endmodule // twe_ctrl_model
`default_nettype wire

// >>> test_two_wire_eeprom_target_front.sv
// Self-checking bench for the two-wire target front end
`timescale 1ns/100ps
`default_nettype none
module test_two_wire_eeprom_target_front;
   // Window shortened so polling fits inside it
   localparam int SELF_TIMED_WRITE_WINDOW = 400;
   logic clk = 1'b0, rst_n = 1'b0, wp = 1'b0, rdy = 1'b0, rd = 1'b0;
   logic sel_h = 1'b1, sel_l = 1'b0, a;
   logic [7:0] b, rpat = 8'h3C;
   int ridx = 0, n_fail = 0, tests_run = 0;
   wire scl, ctl_sda, o_sda, oe_n, rd_req, wvalid, fstart, commit, rmode;
   wire sel, standby, busy;
   wire [7:0] wdata;
   // Open-drain line with pull-up
   wire sda = ctl_sda & (oe_n | o_sda);
   twe_target #(.TWR_CYCLES(SELF_TIMED_WRITE_WINDOW)) dut_u (
      .I_CLK(clk), .I_RESET_N(rst_n), .I_SCL(scl), .I_SDA(sda),
      .O_SDA(o_sda), .O_SDA_OE_N(oe_n), .I_SELECT_PIN_HIGH(sel_h),
      .I_SELECT_PIN_LOW(sel_l), .I_WRITE_PROTECT(wp), .I_READ_DATA(rd),
      .O_READ_DATA_REQ(rd_req), .O_WORD_VALID(wvalid), .I_WORD_READY(rdy),
      .O_WORD_DATA(wdata), .O_FRAME_START(fstart), .O_WRITE_COMMIT(commit),
      .O_READ_MODE(rmode), .O_SELECTED(sel), .O_STANDBY(standby),
      .O_WRITE_BUSY(busy));
   twe_ctrl_model ctl_u (.o_scl(scl), .o_sda(ctl_sda), .i_sda(sda));
   initial forever #5 clk = ~clk;
   always @(negedge clk) begin
      if (rd_req) ridx = ridx + 1;
      rd = rpat[7 - ridx[2:0]];
   end
   // Nine bits so valid flag and word are judged together
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic addr(input logic [1:0] s, input logic rw);
      ctl_u.start();
      ctl_u.send_byte({5'h14, s, rw}, a);
   endtask
   task automatic idle(input int n);
      ctl_u.stop();
      repeat (n) @(negedge clk);
   endtask
   task automatic t_addr;
      for (int s = 0; s < 4; s++) begin
         addr(s[1:0], 1'b0);
         idle(8);
         chk(a, s != 2);
         chk(standby, 1'b1);
      end
      ctl_u.start();
      ctl_u.send_byte(8'hB4, a);
      idle(8);
      chk(a, 1'b1);
      sel_l = 1'bz;
      addr(2'b10, 1'b0);
      idle(8);
      chk(a, 1'b0);
   endtask
   task automatic t_write;
      addr(2'b10, 1'b0);
      chk(a, 1'b0);
      ctl_u.send_byte(8'hA5, a);
      @(negedge clk);
      chk(a, 1'b0);
      chk({wvalid, wdata}, 9'h1A5);
      rdy = 1'b1;
      @(negedge clk);
      rdy = 1'b0;
      idle(0);
      for (int n = 0; n < 50 && !busy; n++) @(negedge clk);
      chk(busy, 1'b1);
      addr(2'b10, 1'b0);
      idle(SELF_TIMED_WRITE_WINDOW);
      chk(a, 1'b1);
      chk({busy, standby}, 2'b01);
   endtask
   task automatic t_wp;
      wp = 1'b1;
      addr(2'b10, 1'b0);
      ctl_u.send_byte(8'h5A, a);
      idle(8);
      chk(a, 1'b1);
      chk({wvalid, busy}, 2'b00);
      wp = 1'b0;
   endtask
   task automatic t_fifo;
      addr(2'b10, 1'b0);
      for (int i = 0; i < 17; i++) begin
         ctl_u.send_byte(i[7:0], a);
         chk(a, i == 16);
      end
      idle(SELF_TIMED_WRITE_WINDOW + 100);
      rdy = 1'b1;
      for (int i = 0; i < 16; i++) begin
         chk({wvalid, wdata}, {1'b1, i[7:0]});
         @(negedge clk);
      end
      rdy = 1'b0;
      chk(wvalid, 1'b0);
   endtask
   task automatic t_read;
      addr(2'b10, 1'b1);
      chk({a, rmode}, 2'b01);
      ctl_u.recv_byte(1'b1, b);
      chk(b, rpat);
      idle(8);
      chk(standby, 1'b1);
   endtask
   task automatic t_recover;
      addr(2'b10, 1'b0);
      ctl_u.recover();
      addr(2'b10, 1'b0);
      idle(8);
      chk(a, 1'b0);
   endtask
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (10) @(negedge clk);
      chk({standby, oe_n, wvalid}, 3'b110);
      t_addr();
      t_write();
      t_wp();
      t_fifo();
      t_read();
      t_recover();
      final_report();
   end
   // Whole run needs under 150 us of bus time
   initial begin
      #400us;
      n_fail++;
      final_report();
   end
endmodule // test_two_wire_eeprom_target_front
`default_nettype wire
